// ### src/uart_cmd_pkg.sv
// Purpose: shared constants and the serial engine of the command link
// Assumes: 200 MHz clk, link at 115200 baud, 8 data bits, no parity, 1 stop
// Notes:   uart_step is the one rx/tx engine used by both ends
`default_nettype none
package uart_cmd_pkg;
    // ------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ      = 200_000_000;
    localparam int          BAUD        = 115_200;
    localparam logic [10:0] BIT_CYC     = 11'(CLK_HZ / BAUD);
    localparam logic [10:0] HALF_CYC    = 11'(CLK_HZ / BAUD / 2);
    localparam int          TIMEOUT_DEF = 20 * (CLK_HZ / BAUD);

    // ------------------------------------------------------------
    // function and message codes
    // ------------------------------------------------------------
    localparam logic [7:0] FN_TOUCH  = 8'h03;
    localparam logic [7:0] FN_ROM_WR = 8'h21;
    localparam logic [7:0] FN_BLOCK  = 8'h24;
    localparam logic [7:0] MSG_TOUCH = 8'h50;
    localparam logic [7:0] MSG_READY = 8'h53;
    localparam logic [7:0] MSG_TMO   = 8'h54;
    localparam logic [7:0] MSG_BUSY  = 8'h57;
    localparam logic [7:0] MSG_CKSUM = 8'h58;
    localparam logic [7:0] RSV_LO    = MSG_TOUCH;
    localparam logic [7:0] RSV_HI    = 8'h5F;
    localparam logic [7:0] LEAD0     = 8'h55;
    localparam logic [7:0] LEAD1     = 8'hAA;

    // ------------------------------------------------------------
    // serial engine state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        rbusy;
        logic [10:0] rcnt;
        logic [3:0]  rbit;
        logic [7:0]  rsh;
        logic        rstb;
        logic        tbusy;
        logic [10:0] tcnt;
        logic [3:0]  tbit;
        logic [9:0]  tsh;
        logic        txd;
    } uart_t;

    localparam uart_t UART_RST = '{s1: 1'b1, s2: 1'b1, txd: 1'b1, default: '0};

    function automatic uart_t uart_step(uart_t u, logic rxd, logic load, logic [7:0] d);
        uart_t n;
        n      = u;
        n.s1   = rxd;
        n.s2   = u.s1;
        n.rstb = 1'b0;
        if (!u.rbusy) begin
            if (!u.s2) begin
                n.rbusy = 1'b1;
                n.rcnt  = HALF_CYC;
                n.rbit  = 4'h0;
            end
        end else if (u.rcnt != 11'h000) begin
            n.rcnt = u.rcnt - 11'h001;
        end else begin
            n.rcnt = BIT_CYC - 11'h001;
            n.rbit = u.rbit + 4'h1;
            if (u.rbit == 4'h0) begin
                n.rbusy = u.s2 ? 1'b0 : 1'b1;
            end else if (u.rbit < 4'h9) begin
                n.rsh = {u.s2, u.rsh[7:1]};
            end else begin
                n.rbusy = 1'b0;
                n.rstb  = u.s2;
            end
        end
        if (!u.tbusy) begin
            n.txd = 1'b1;
            if (load) begin
                n.tbusy = 1'b1;
                n.tsh   = {1'b1, d, 1'b0};
                n.tcnt  = BIT_CYC - 11'h001;
                n.tbit  = 4'h0;
                n.txd   = 1'b0;
            end
        end else if (u.tcnt != 11'h000) begin
            n.tcnt = u.tcnt - 11'h001;
        end else if (u.tbit == 4'h9) begin
            n.tbusy = 1'b0;
        end else begin
            n.tbit = u.tbit + 4'h1;
            n.tsh  = {1'b1, u.tsh[9:1]};
            n.txd  = u.tsh[1];
            n.tcnt = BIT_CYC - 11'h001;
        end
        return n;
    endfunction
endpackage
`default_nettype wire

// ### src/uart_link_if.sv
// Purpose: the two serial wires between host and device
// Assumes: both ends on the same clk in simulation
// Notes:   idle level of both wires is high
`timescale 1ns/100ps
`default_nettype none
interface uart_link_if;
    logic dev_txd;
    logic host_txd;
    modport device (input host_txd, output dev_txd);
    modport host   (input dev_txd, output host_txd);
endinterface
`default_nettype wire

// ### src/cmd_stream_host.sv
// Purpose: host end; sends command streams, follows the reply handshake
// Assumes: user gives each stream byte by byte, checksum included
// Notes:   pauses on busy, resumes on ready, one stream in flight
`timescale 1ns/100ps
`default_nettype none
module cmd_stream_host
    import uart_cmd_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // serial link
    uart_link_if.host       link,
    // stream bytes to send
    input  wire logic       send_valid,
    input  wire logic [7:0] send_data,
    input  wire logic       send_first,
    output var  logic       send_ready,
    // reply bytes and status
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    output var  logic       done,
    output var  logic       retry,
    output var  logic       paused,
    output var  logic       waiting
);
    typedef struct packed {
        uart_t      u;
        logic       sready;
        logic       paused;
        logic       waiting;
        logic       bulk_ok;
        logic       lead;
        logic       tail;
        logic [2:0] skip;
        logic [7:0] lcode;
        logic       rv;
        logic [7:0] rd;
        logic       done;
        logic       retry;
    } host_t;

    localparam host_t HOST_RST = '{u: UART_RST, default: '0};

    host_t      s;
    host_t      n;
    logic       take;
    logic [7:0] b;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n       = s;
        n.rv    = 1'b0;
        n.done  = 1'b0;
        n.retry = 1'b0;
        b       = s.u.rsh;
        take = send_valid & s.sready
             & (~send_first | (~s.waiting & ((send_data != LEAD0) | s.bulk_ok)));
        n.u = uart_step(s.u, link.dev_txd, take, send_data);
        if (take && send_first) begin
            n.waiting = 1'b1;
            n.lcode   = send_data;
        end
        if (s.u.rstb) begin
            n.rv = 1'b1;
            n.rd = b;
            if (s.skip != 3'h0) begin
                n.skip = s.skip - 3'h1;
            end else if (s.tail) begin
                n.tail = 1'b0;
                n.skip = (b == LEAD0) ? 3'h1 : 3'h0;
            end else if (b == MSG_BUSY) begin
                n.paused = 1'b1;
                n.tail   = 1'b1;
            end else if (b == MSG_READY) begin
                n.paused = 1'b0;
                n.tail   = 1'b1;
            end else if (b == MSG_CKSUM || b == MSG_TMO) begin
                n.retry   = 1'b1;
                n.waiting = 1'b0;
                n.tail    = 1'b1;
            end else if (b == MSG_TOUCH) begin
                n.skip = 3'h4;
            end else if (b == LEAD0) begin
                n.lead = 1'b1;
            end else if (s.lead && b == LEAD1) begin
                n.lead    = 1'b0;
                n.done    = s.waiting;
                n.waiting = 1'b0;
                n.bulk_ok = 1'b0;
            end else if (s.waiting && b == s.lcode) begin
                n.done    = 1'b1;
                n.waiting = 1'b0;
                n.bulk_ok = (b == FN_ROM_WR) || (b == FN_BLOCK);
            end
        end
        n.sready = ~n.paused & ~n.u.tbusy;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= HOST_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.host_txd = s.u.txd;
    assign send_ready    = s.sready;
    assign rx_valid      = s.rv;
    assign rx_data       = s.rd;
    assign done          = s.done;
    assign retry         = s.retry;
    assign paused        = s.paused;
    assign waiting       = s.waiting;
endmodule // cmd_stream_host
`default_nettype wire

// ### src/cmd_stream_device.sv
// Purpose: device end; parses command streams, replies with status codes
// Assumes: executor looks up param_len for cmd_code, pulses exec_done
// Notes:   parameters and bulk data leave through a two-entry buffer
//
// What this block does
// - link is 115200 baud, 8N1
// - frame: code, parameters, checksum
// - checksum checked before command runs
// - codes 0x50..0x5F never function codes
// - success echoes the function code
// - bulk success replies 0x55 0xAA
// - checksum error sends 0x58 plus tail
// - timeout sends 0x54 plus tail
// - busy sends 0x57; host pauses
// - ready sends 0x53; host continues
// - touch sends 0x50 and coordinates
// - no touch reports during bulk stage
// - host may poll touch with 0x03
// - only 0x21, 0x24 open bulk stage
// - bulk: 0x55 0xAA, length, data, checksum
// - length byte is count minus one
// - host starts stream after success
// - bulk write data after 0x21 echo
`timescale 1ns/100ps
`default_nettype none
module cmd_stream_device
    import uart_cmd_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_DEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // serial link
    uart_link_if.device      link,
    // command executor
    output var  logic [7:0]  cmd_code,
    input  wire logic [7:0]  param_len,
    output var  logic        cmd_go,
    output var  logic        cmd_abort,
    input  wire logic        exec_done,
    output var  logic        bulk_stage,
    output var  logic        bulk_ok,
    // parameter and bulk bytes
    output var  logic        out_valid,
    output var  logic [7:0]  out_data,
    output var  logic        out_bulk,
    input  wire logic        out_ready,
    // touch panel
    input  wire logic        touch_irq,
    input  wire logic [15:0] touch_x,
    input  wire logic [15:0] touch_y
);
    typedef enum logic [3:0] {
        ST_CODE, ST_PLEN, ST_PARAM, ST_SUM, ST_EXEC,
        ST_LEAD1, ST_LEN, ST_DATA, ST_BSUM, ST_RPLY
    } dev_st_t;

    typedef struct packed {
        uart_t       u;
        dev_st_t     st;
        logic [7:0]  code;
        logic [7:0]  sum;
        logic [7:0]  left;
        logic        bulk_pend;
        logic [39:0] rply;
        logic [2:0]  rcnt;
        logic [39:0] hold;
        logic [2:0]  hcnt;
        logic        busy;
        logic        told;
        logic [23:0] tmo;
        logic        tpend;
        logic [31:0] txy;
        logic        ov0;
        logic        ov1;
        logic [8:0]  ob0;
        logic [8:0]  ob1;
        logic        go;
        logic        abort;
        logic        bok;
    } dev_t;

    localparam dev_t        DEV_RST = '{u: UART_RST, st: ST_CODE, default: '0};
    localparam logic [23:0] TO_LAST = 24'(TIMEOUT_CYC - 1);

    dev_t        s;
    dev_t        n;
    logic        load;
    logic        rxv;
    logic [7:0]  rxb;
    logic        frame;
    logic        free;
    logic        push;
    logic [8:0]  pdata;
    logic [39:0] tail;
    logic [2:0]  tlen;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n       = s;
        n.go    = 1'b0;
        n.abort = 1'b0;
        n.bok   = 1'b0;
        push    = 1'b0;
        pdata   = 9'h000;
        rxv     = s.u.rstb;
        rxb     = s.u.rsh;
        free    = (s.rcnt == 3'h0);
        frame   = s.st inside {ST_PLEN, ST_PARAM, ST_SUM, ST_LEAD1, ST_LEN, ST_DATA, ST_BSUM};
        // message tail: function code or bulk leader
        tail = s.bulk_pend ? {8'h00, LEAD0, LEAD1, 16'h0000} : {8'h00, s.code, 24'h000000};
        tlen = s.bulk_pend ? 3'h3 : 3'h2;

        // reply queue drains one byte per free transmitter
        load = ~free & ~s.u.tbusy;
        n.u  = uart_step(s.u, link.host_txd, load, s.rply[39:32]);
        if (load) begin
            n.rply = {s.rply[31:0], 8'h00};
            n.rcnt = s.rcnt - 3'h1;
        end

        if (s.ov0 && out_ready) begin
            n.ob0 = s.ob1;
            n.ov0 = s.ov1;
            n.ov1 = 1'b0;
        end

        if (s.ov0 && !out_ready && frame) begin
            n.busy = 1'b1;
        end else if (!s.ov0) begin
            n.busy = 1'b0;
        end

        if (free && s.busy != s.told) begin
            n.rply = {(s.busy ? MSG_BUSY : MSG_READY), tail[31:0]};
            n.rcnt = tlen;
            n.told = s.busy;
        end else if (free && s.st == ST_RPLY) begin
            n.rply = s.hold;
            n.rcnt = s.hcnt;
            n.st   = ST_CODE;
        end else if (free && s.st == ST_CODE && s.tpend) begin
            n.rply  = {MSG_TOUCH, s.txy};
            n.rcnt  = 3'h5;
            n.tpend = 1'b0;
        end

        if (s.bulk_pend) begin
            n.tpend = 1'b0;
        end else if (touch_irq) begin
            n.tpend = 1'b1;
            n.txy   = {touch_x, touch_y};
        end

        if (frame && !s.busy && !rxv) begin
            n.tmo = s.tmo + 24'h000001;
        end else begin
            n.tmo = 24'h000000;
        end

        unique case (s.st)
            ST_CODE: begin
                if (rxv) begin
                    if (s.bulk_pend && rxb == LEAD0) begin
                        n.st = ST_LEAD1;
                    end else if (rxb < RSV_LO || rxb > RSV_HI) begin
                        n.code      = rxb;
                        n.sum       = rxb;
                        n.bulk_pend = 1'b0;
                        n.st        = ST_PLEN;
                    end
                end
            end
            ST_PLEN: begin
                n.left = param_len;
                n.st   = (param_len == 8'h00) ? ST_SUM : ST_PARAM;
            end
            ST_PARAM: begin
                if (rxv) begin
                    push   = 1'b1;
                    pdata  = {1'b0, rxb};
                    n.sum  = s.sum + rxb;
                    n.left = s.left - 8'h01;
                    if (s.left == 8'h01) begin
                        n.st = ST_SUM;
                    end
                end
            end
            ST_SUM: begin
                if (rxv) begin
                    if (rxb == s.sum) begin
                        n.go = 1'b1;
                        n.st = ST_EXEC;
                    end else begin
                        n.abort = 1'b1;
                        n.hold  = {MSG_CKSUM, tail[31:0]};
                        n.hcnt  = tlen;
                        n.st    = ST_RPLY;
                    end
                end
            end
            ST_EXEC: begin
                if (exec_done) begin
                    n.hold = {s.code, 32'h00000000};
                    n.hcnt = 3'h1;
                    n.bulk_pend = (s.code == FN_ROM_WR) || (s.code == FN_BLOCK);
                    n.st        = ST_RPLY;
                end
            end
            ST_LEAD1: begin
                if (rxv) begin
                    n.st = (rxb == LEAD1) ? ST_LEN : ST_CODE;
                end
            end
            ST_LEN: begin
                if (rxv) begin
                    n.left = rxb;
                    n.sum  = rxb;
                    n.st   = ST_DATA;
                end
            end
            ST_DATA: begin
                if (rxv) begin
                    push   = 1'b1;
                    pdata  = {1'b1, rxb};
                    n.sum  = s.sum + rxb;
                    n.left = s.left - 8'h01;
                    if (s.left == 8'h00) begin
                        n.st = ST_BSUM;
                    end
                end
            end
            ST_BSUM: begin
                if (rxv) begin
                    if (rxb == s.sum) begin
                        n.bok       = 1'b1;
                        n.bulk_pend = 1'b0;
                        n.hold      = {LEAD0, LEAD1, 24'h000000};
                        n.hcnt      = 3'h2;
                    end else begin
                        n.abort = 1'b1;
                        n.hold  = {MSG_CKSUM, tail[31:0]};
                        n.hcnt  = tlen;
                    end
                    n.st = ST_RPLY;
                end
            end
            ST_RPLY: begin
            end
        endcase

        if (frame && s.tmo == TO_LAST && !rxv) begin
            n.abort = 1'b1;
            n.hold  = {MSG_TMO, tail[31:0]};
            n.hcnt  = tlen;
            n.tmo   = 24'h000000;
            n.st    = ST_RPLY;
        end

        if (push) begin
            if (!n.ov0) begin
                n.ob0 = pdata;
                n.ov0 = 1'b1;
            end else begin
                n.ob1 = pdata;
                n.ov1 = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= DEV_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.dev_txd = s.u.txd;
    assign cmd_code     = s.code;
    assign cmd_go       = s.go;
    assign cmd_abort    = s.abort;
    assign bulk_stage   = s.bulk_pend;
    assign bulk_ok      = s.bok;
    assign out_valid    = s.ov0;
    assign out_data     = s.ob0[7:0];
    assign out_bulk     = s.ob0[8];
endmodule // cmd_stream_device
`default_nettype wire

// ### sim/uart_cmd_link_assertions.sv
// Purpose: link and handshake checks between host and device ends
// Assumes: one clk, rst synchronous active high
// Notes:   watches the serial wires and both user sides
`timescale 1ns/100ps
`default_nettype none
module uart_cmd_link_checker
    import uart_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial wires
    input wire logic dev_txd,
    input wire logic host_txd,
    // device user side
    input wire logic cmd_go,
    input wire logic cmd_abort,
    input wire logic exec_done,
    input wire logic out_valid,
    input wire logic out_bulk,
    input wire logic bulk_stage,
    // host user side
    input wire logic send_valid,
    input wire logic send_first,
    input wire logic send_ready,
    input wire logic paused,
    input wire logic done,
    input wire logic retry,
    input wire logic waiting
);
    localparam int BITC = int'(BIT_CYC);
    logic        dprev_ff;
    logic        hprev_ff;
    logic [15:0] drun_ff;
    logic [15:0] hrun_ff;

    // ------------------------------------------------
    // run length of the current line level
    // ------------------------------------------------
    always_ff @(posedge clk) begin
        dprev_ff <= rst | dev_txd;
        hprev_ff <= rst | host_txd;
        drun_ff  <= (rst || dev_txd != dprev_ff) ? 16'h0001 : drun_ff + 16'h0001;
        hrun_ff  <= (rst || host_txd != hprev_ff) ? 16'h0001 : hrun_ff + 16'h0001;
    end

    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_dev_bit_len: assert property (dev_txd && !dprev_ff
        |-> int'(drun_ff) % BITC == 0 && int'(drun_ff) <= 9 * BITC)
        else $error("device low run not whole bits");
    a_host_bit_len: assert property (host_txd && !hprev_ff
        |-> int'(hrun_ff) % BITC == 0 && int'(hrun_ff) <= 9 * BITC)
        else $error("host low run not whole bits");
    a_send_start_bit: assert property (send_valid && send_ready && !send_first && !paused
        |=> !host_txd && !send_ready)
        else $error("host byte taken without start bit");
    a_go_abort_excl: assert property (!(cmd_go && cmd_abort))
        else $error("go and abort together");
    a_verdict_stop_bit: assert property ((cmd_go || cmd_abort) |-> host_txd ##1 !cmd_go)
        else $error("verdict outside stop bit or long");
    a_abort_reply: assert property (cmd_abort |-> ##[1:20] !dev_txd)
        else $error("no error reply after abort");
    a_echo_start: assert property (exec_done |-> ##[1:20] !dev_txd)
        else $error("no echo after execution");
    a_end_clears: assert property ((done || retry) |=> !waiting)
        else $error("host still waiting after reply");
    a_std_not_bulk: assert property (out_valid && !bulk_stage |-> !out_bulk)
        else $error("bulk byte outside bulk stage");

    c_go: cover property (cmd_go);
    c_abort: cover property (cmd_abort);
    c_done: cover property (done);
    c_retry: cover property (retry);
endmodule // uart_cmd_link_checker
`default_nettype wire

// ### sim/uart_command_stream_handshake_test.sv
// Purpose: host and device ends joined, frames and replies checked
// Assumes: 200 MHz clk, full bit time on the wire
// Notes:   code 0x10 carries one parameter, all others none
`timescale 1ns/100ps
`default_nettype none
module uart_command_stream_handshake_test;
    import uart_cmd_pkg::*;
    logic        clk, rst, exec_done, out_ready, touch_irq;
    logic        send_valid, send_first, send_ready, rx_valid, done, retry, paused, waiting;
    logic        cmd_go, cmd_abort, bulk_stage, bulk_ok, out_valid, out_bulk;
    logic [7:0]  send_data, rx_data, cmd_code, param_len, out_data;
    logic [15:0] touch_x, touch_y;
    logic [7:0]  got[$], od[$];
    int          n_fail, total_checks, cyc, ngo, nab, ndone, nretry;

    uart_link_if link ();
    cmd_stream_host cmd_stream_host_inst (.clk, .rst, .link(link), .send_valid, .send_data,
        .send_first, .send_ready, .rx_valid, .rx_data, .done, .retry, .paused, .waiting);
    cmd_stream_device #(.TIMEOUT_CYC(40000)) cmd_stream_device_inst (.clk, .rst, .link(link),
        .cmd_code, .param_len, .cmd_go, .cmd_abort, .exec_done, .bulk_stage, .bulk_ok,
        .out_valid, .out_data, .out_bulk, .out_ready, .touch_irq, .touch_x, .touch_y);
    uart_cmd_link_checker uart_cmd_link_checker_inst (.clk, .rst, .dev_txd(link.dev_txd),
        .host_txd(link.host_txd), .cmd_go, .cmd_abort, .exec_done, .out_valid, .out_bulk,
        .bulk_stage, .send_valid, .send_first, .send_ready, .paused, .done, .retry, .waiting);

    assign param_len = (cmd_code == 8'h10) ? 8'h01 : 8'h00;
    assign out_ready = 1'b1;
    assign touch_irq = 1'b0;
    assign touch_x = 16'h0000;
    assign touch_y = 16'h0000;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------
    // executor and event log
    // ------------------------------------------------
    always @(negedge clk) exec_done <= (cmd_go === 1'b1);

    always @(negedge clk) begin
        cyc++;
        if (rx_valid === 1'b1)
            got.push_back(rx_data);
        if (out_valid === 1'b1)
            od.push_back(out_data);
        ngo += int'(cmd_go === 1'b1);
        nab += int'(cmd_abort === 1'b1);
        ndone += int'(done === 1'b1);
        nretry += int'(retry === 1'b1);
        if (cyc == 250000) begin
            n_fail++;
            $display("timeout at %0t", $time);
            end_sim();
        end
    end

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic put(input logic [7:0] d, input logic f);
        int k;
        @(negedge clk);
        send_valid = 1'b1;
        send_data = d;
        send_first = f;
        k = 0;
        while (send_ready !== 1'b1 && k < 40000) begin
            @(negedge clk);
            k++;
        end
        if (k == 40000) begin
            n_fail++;
            $display("send stalled at %0t", $time);
        end
        @(negedge clk);
        send_valid = 1'b0;
        send_first = 1'b0;
    endtask

    task automatic wait_rx(input int n);
        for (int k = 0; k < 80000 && (got.size() < n || waiting === 1'b1); k++)
            @(posedge clk);
        @(negedge clk);
        if (got.size() < n || waiting === 1'b1) begin
            n_fail++;
            $display("reply missing at %0t", $time);
        end
    endtask

    task automatic clear_log();
        got.delete();
        od.delete();
        {ngo, nab, ndone, nretry} = '0;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic std_ok();
        clear_log();
        put(8'h10, 1'b1);
        put(8'hA5, 1'b0);
        put(8'hB5, 1'b0);
        wait_rx(1);
        chk(got[0], 8'h10);
        chk(od[0], 8'hA5);
        chk(8'(ngo), 8'h01);
        chk(8'(nab), 8'h00);
        chk(8'(ndone), 8'h01);
        $display("test std_ok end");
    endtask

    task automatic cks_bad();
        clear_log();
        put(8'h52, 1'b0);
        put(8'h03, 1'b1);
        put(8'h04, 1'b0);
        wait_rx(2);
        chk(got[0], 8'h58);
        chk(got[1], 8'h03);
        chk(8'(ngo), 8'h00);
        chk(8'(nab), 8'h01);
        chk(8'(nretry), 8'h01);
        chk({7'h00, waiting}, 8'h00);
        $display("test cks_bad end");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        exec_done = 1'b0;
        send_valid = 1'b0;
        send_first = 1'b0;
        send_data = 8'h00;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        std_ok();
        cks_bad();
        end_sim();
    end
endmodule // uart_command_stream_handshake_test
`default_nettype wire
